// ===== src/tks_map.vh
// Constants for the touch sensor SPI access block.
// Included by tks_spi_access.v and tks_crc16.v; definitions only.
`ifndef TKS_MAP_VH
`define TKS_MAP_VH

// ----------------------------------------------------------------------
// Locations
// ----------------------------------------------------------------------
`define TKS_LOC_TICK        8'h02
`define TKS_LOC_FAIL        8'h03
`define TKS_LOC_SCAN        8'h04
`define TKS_LOC_CMD         8'h8c
`define TKS_LOC_SETUP_FIRST 8'h8d
`define TKS_LOC_SETUP_LAST  8'hfa
`define TKS_CMD_UNLOCK      8'hfe

// ----------------------------------------------------------------------
// Count byte fields
// ----------------------------------------------------------------------
`define TKS_DIR_BIT         7
`define TKS_CNT_MSB         6

// ----------------------------------------------------------------------
// Reset values and CRC polynomial
// ----------------------------------------------------------------------
`define TKS_CNT_RESET       8'h00
`define TKS_CRC_INIT        16'hffff
`define TKS_CRC_POLY        16'h1021

// ----------------------------------------------------------------------
// Timing at 100 MHz
// ----------------------------------------------------------------------
`define TKS_CLK_MHZ         100
`define TKS_GAP_US          40
`define TKS_GAP_CYC         (`TKS_GAP_US * `TKS_CLK_MHZ)
`define TKS_TICK_MS         100
`define TKS_TICK_CYC        (`TKS_TICK_MS * 1000 * `TKS_CLK_MHZ)

`endif

// ===== src/tks_crc16.v
// Bytewise 16-bit CRC engine, MSB-first, polynomial and seed parameters.
// Assumes the caller presents one byte per strobe on the same clock.
`timescale 1ns/1ps
`include "tks_map.vh"

module tks_crc16
#(
   parameter [15:0] POLY = `TKS_CRC_POLY,
   parameter [15:0] INIT = `TKS_CRC_INIT
)
(
   // Clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // Control and data
   input  wire        clear_i,
   input  wire        feed_i,
   input  wire [7:0]  byte_i,
   output wire [15:0] crc_o
);

   reg  [15:0] crc_q;
   reg  [15:0] crc_d;
   integer     i;

   // ----------------------------------------------------------------------
   // Next value, one bit per step
   // ----------------------------------------------------------------------
   always @*
   begin
      crc_d = crc_q;
      for (i = 7; i >= 0; i = i - 1)
      begin
         if (crc_d[15] ^ byte_i[i])
            crc_d = {crc_d[14:0], 1'b0} ^ POLY;
         else
            crc_d = {crc_d[14:0], 1'b0};
      end
   end

   // Clear wins over feed so a new read starts from the seed
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         crc_q <= INIT;
      else if (ce_i)
      begin
         if (clear_i)
            crc_q <= INIT;
         else if (feed_i)
            crc_q <= crc_d;
      end
   end

   assign crc_o = crc_q;

endmodule

// ===== src/tks_spi_access.v
// SPI slave access protocol of a touch sensor with safety counters.
// Assumes SPI mode 0, host as master, pins sampled by ref_clk_i.
//
// Functional notes
// - Count MSB 0 writes, 1 to 127 bytes.
// - 40 us gap and ready high between bytes.
// - Write stores byte, then advances location.
// - Bytes returned during writes are undefined.
// - Count MSB 1 reads 1 to 127 bytes.
// - Read returns location, then advances location.
// - CRC follows data, low byte first.
// - CRC covers location, count, data in order.
// - Bytes during read header are undefined.
// - Full duplex, one byte back per byte.
// - Location 2 ticks every 100 ms, wraps.
// - Location 3 counts capture failures.
// - Location 4 counts scans before each starts.
// - Setups locked; unlock code unlocks; reads relock.
`timescale 1ns/1ps
`include "tks_map.vh"

module tks_spi_access
#(
   parameter TICK_CYC = `TKS_TICK_CYC
)
(
   // Clock, reset, enable
   input  wire       ref_clk_i,
   input  wire       rst_i,
   input  wire       ce_i,
   // SPI pins
   input  wire       sclk_i,
   input  wire       ss_n_i,
   input  wire       mosi_i,
   output reg        miso_o,
   output reg        byte_ready_handshake_o,
   // Device events
   input  wire       capture_fail_i,
   input  wire       scan_start_i,
   // Setup area write port
   output reg        setup_we_o,
   output reg  [7:0] setup_addr_o,
   output reg  [7:0] setup_wdata_o,
   input  wire [7:0] setup_rdata_i,
   output reg        setup_unlocked_o
);

   localparam [1:0] ST_LOC  = 2'd0;
   localparam [1:0] ST_CNT  = 2'd1;
   localparam [1:0] ST_DATA = 2'd2;
   localparam [1:0] ST_CRC  = 2'd3;
   localparam [31:0] GAP_FULL  = `TKS_GAP_CYC;      // Cut on purpose below
   localparam [31:0] TICK_FULL = TICK_CYC - 1;
   localparam [12:0] GAP_CYC   = GAP_FULL[12:0];
   localparam [23:0] TICK_LAST = TICK_FULL[23:0];

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   reg [2:0] sclk_s_q;
   reg [1:0] ss_s_q;
   reg [1:0] mosi_s_q;

   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sclk_s_q <= 3'h0;
         ss_s_q   <= 2'h3;
         mosi_s_q <= 2'h0;
      end
      else if (ce_i)
      begin
         sclk_s_q <= {sclk_s_q[1:0], sclk_i};
         ss_s_q   <= {ss_s_q[0], ss_n_i};
         mosi_s_q <= {mosi_s_q[0], mosi_i};
      end
   end

   // Edge detect looks only at the second and third stages
   wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
   wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
   wire ss_act    = ~ss_s_q[1];
   wire mosi_s    = mosi_s_q[1];

   // ----------------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------------
   reg [1:0]  st_q;
   reg [2:0]  bit_q;
   reg [7:0]  sh_in_q;
   reg [7:0]  sh_out_q;
   reg [7:0]  loc_q;
   reg [6:0]  left_q;
   reg        rd_q;
   reg        crc_hi_q;
   reg        done_q;
   reg [7:0]  done_byte_q;
   reg [12:0] gap_q;
   reg [15:0] crc_hold_q;

   wire [7:0] rx_byte = {sh_in_q[6:0], mosi_s};
   wire       byte_end = ss_act & sclk_rise & (bit_q == 3'd7);
   wire [15:0] crc_val;
   reg         crc_clr;
   reg         crc_feed;
   reg  [7:0]  crc_byte;

   // Safety counters
   reg [7:0]  tick_cnt_q;
   reg [7:0]  fail_cnt_q;
   reg [7:0]  scan_cnt_q;
   reg [23:0] tick_div_q;

   // Read mux over the internal locations; others come from the setups
   reg [7:0] rd_data;
   always @*
   begin
      case (loc_q)
         `TKS_LOC_TICK: rd_data = tick_cnt_q;
         `TKS_LOC_FAIL: rd_data = fail_cnt_q;
         `TKS_LOC_SCAN: rd_data = scan_cnt_q;
         default:       rd_data = setup_rdata_i;
      endcase
   end

   // CRC feed: seeded while idle, then location and count as they end,
   // then each data byte as it is loaded, so the low byte is ready in time
   always @*
   begin
      crc_clr  = (st_q == ST_LOC) & ~byte_end & ~done_q;
      crc_feed = byte_end & ((st_q == ST_LOC) | (st_q == ST_CNT));
      crc_byte = rx_byte;
      if (done_q & (((st_q == ST_CNT) & done_byte_q[`TKS_DIR_BIT]) |
                    ((st_q == ST_DATA) & rd_q & (left_q != 7'd1))))
      begin
         crc_feed = 1'b1;
         crc_byte = rd_data;
      end
   end

   tks_crc16 u_crc
   (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .clear_i   (crc_clr),
      .feed_i    (crc_feed),
      .byte_i    (crc_byte),
      .crc_o     (crc_val)
   );

   // ----------------------------------------------------------------------
   // Byte shifter and transaction sequencer
   // ----------------------------------------------------------------------
   // done_q marks a byte received; the next cycle acts on it, which keeps
   // the CRC update and the location step in one ordered place.
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q          <= ST_LOC;
         bit_q         <= 3'd0;
         sh_in_q       <= 8'h00;
         sh_out_q      <= 8'h00;
         loc_q         <= 8'h00;
         left_q        <= 7'd0;
         rd_q          <= 1'b0;
         crc_hi_q      <= 1'b0;
         done_q        <= 1'b0;
         done_byte_q   <= 8'h00;
         gap_q         <= 13'd0;
         crc_hold_q    <= 16'h0000;
         miso_o        <= 1'b0;
         byte_ready_handshake_o <= 1'b1;
         setup_we_o    <= 1'b0;
         setup_addr_o  <= 8'h00;
         setup_wdata_o <= 8'h00;
         setup_unlocked_o <= 1'b0;
      end
      else if (ce_i)
      begin
         setup_we_o <= 1'b0;
         done_q     <= 1'b0;
         if (!ss_act)
         begin
            // Deselect aborts any transaction in progress
            st_q  <= ST_LOC;
            bit_q <= 3'd0;
         end
         else
         begin
            if (sclk_rise)
            begin
               sh_in_q <= rx_byte;
               bit_q   <= bit_q + 3'd1;
            end
            if (sclk_fall)
            begin
               sh_out_q <= {sh_out_q[6:0], 1'b0};
               miso_o   <= sh_out_q[7]; // MSB leads the byte
            end
         end
         if (byte_end)
         begin
            done_q      <= 1'b1;
            done_byte_q <= rx_byte;
            byte_ready_handshake_o <= 1'b0;
            gap_q       <= GAP_CYC;
         end
         else if (gap_q != 13'd0)
            gap_q <= gap_q - 13'd1;
         else if (!done_q)
            byte_ready_handshake_o <= 1'b1;

         if (done_q)
         begin
            case (st_q)
               ST_LOC:
               begin
                  loc_q    <= done_byte_q;
                  st_q     <= ST_CNT;
                  sh_out_q <= 8'h00;
               end
               ST_CNT:
               begin
                  rd_q   <= done_byte_q[`TKS_DIR_BIT];
                  left_q <= done_byte_q[`TKS_CNT_MSB:0];
                  if (done_byte_q[`TKS_CNT_MSB:0] == 7'd0)
                     st_q <= ST_LOC;
                  else
                     st_q <= ST_DATA;
                  if (done_byte_q[`TKS_DIR_BIT])
                  begin
                     setup_unlocked_o <= 1'b0;
                     sh_out_q <= rd_data;
                     loc_q    <= loc_q + 8'd1;
                  end
                  else
                     sh_out_q <= 8'h00;
               end
               ST_DATA:
               begin
                  left_q <= left_q - 7'd1;
                  if (rd_q)
                  begin
                     sh_out_q <= rd_data;
                     loc_q    <= loc_q + 8'd1;
                     if (left_q == 7'd1)
                     begin
                        st_q     <= ST_CRC;
                        crc_hi_q <= 1'b0;
                        // Every data byte is fed by now: low byte next
                        sh_out_q   <= crc_val[7:0];
                        crc_hold_q <= crc_val;
                     end
                  end
                  else
                  begin
                     // Store, then step the location for the next byte
                     sh_out_q <= 8'h00;
                     loc_q    <= loc_q + 8'd1;
                     if ((loc_q == `TKS_LOC_CMD) &&
                         (done_byte_q == `TKS_CMD_UNLOCK))
                        setup_unlocked_o <= 1'b1;
                     else if (setup_unlocked_o &&
                              (loc_q >= `TKS_LOC_SETUP_FIRST) &&
                              (loc_q <= `TKS_LOC_SETUP_LAST))
                     begin
                        setup_we_o    <= 1'b1;
                        setup_addr_o  <= loc_q;
                        setup_wdata_o <= done_byte_q;
                     end
                     if (left_q == 7'd1)
                        st_q <= ST_LOC;
                  end
               end
               ST_CRC:
               begin
                  crc_hi_q <= 1'b1;
                  if (crc_hi_q)
                  begin
                     st_q     <= ST_LOC;
                     sh_out_q <= 8'h00;
                  end
                  else
                     sh_out_q <= crc_hold_q[15:8];
               end
               default:
                  st_q <= ST_LOC;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Safety counters
   // ----------------------------------------------------------------------
   always @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tick_div_q <= 24'd0;
         tick_cnt_q <= `TKS_CNT_RESET;
         fail_cnt_q <= `TKS_CNT_RESET;
         scan_cnt_q <= `TKS_CNT_RESET;
      end
      else if (ce_i)
      begin
         if (tick_div_q == TICK_LAST)
         begin
            tick_div_q <= 24'd0;
            tick_cnt_q <= tick_cnt_q + 8'd1;
         end
         else
            tick_div_q <= tick_div_q + 24'd1;
         if (capture_fail_i)
            fail_cnt_q <= fail_cnt_q + 8'd1;
         if (scan_start_i)
            scan_cnt_q <= scan_cnt_q + 8'd1;
      end
   end

endmodule

// ===== test/tks_host.sv
// Host model: SPI master, mode 0, 125 ns bit period.
// Assumes the device ready line is a plain level.
`timescale 1ns/1ps
module tks_host
(
   // Device side
   input  wire  ready_i,
   input  wire  miso_i,
   output logic sclk_o,
   output logic ss_n_o,
   output logic mosi_o
);
   // Link clock still and select idle outside frames
   initial
   begin
      sclk_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // One byte each way, then the mandatory gap
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      integer i;
      wait (ready_i === 1'b1);
      ss_n_o = 1'b0;
      for (i = 7; i >= 0; i--)
      begin
         mosi_o = tx[i];
         #62.5 sclk_o = 1'b1;
         rx[i] = miso_i;
         #62.5 sclk_o = 1'b0;
      end
      // Stale data must not look valid
      mosi_o = ~tx[0];
      #40000;
   endtask

   // Release select after the last byte
   task automatic done_frame;
      ss_n_o = 1'b1;
      #500;
   endtask
endmodule

// ===== test/tks_chk_asserts.sv
// Checker of the access block's setup port and ready line.
// Assumes one clock domain; bound to every instance.
`timescale 1ns/1ps
module tks_chk
(
   input wire       ref_clk_i,
   input wire       rst_i,
   input wire       ss_n_i,
   input wire       byte_ready_handshake_o,
   input wire       setup_we_o,
   input wire [7:0] setup_addr_o,
   input wire       setup_unlocked_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic [12:0] low_q;
   logic [7:0]  last_q;
   logic        seen_q;

   // Ready-low length and last write location in this frame
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         low_q  <= 13'h0;
         last_q <= 8'h00;
         seen_q <= 1'b0;
      end
      else
      begin
         low_q  <= byte_ready_handshake_o ? 13'h0 : low_q + 13'h1;
         seen_q <= !ss_n_i && (seen_q || setup_we_o);
         if (setup_we_o)
            last_q <= setup_addr_o;
      end
   end

   sequence s_pulse;
      setup_we_o ##1 !setup_we_o;
   endsequence

   a_we_pulse: assert property (setup_we_o |-> s_pulse)
      else $error("write strobe longer than one cycle");
   a_gap_min: assert property ($rose(byte_ready_handshake_o) |-> low_q >= 13'd3999)
      else $error("ready low too short");
   a_gap_max: assert property (low_q <= 13'd4100)
      else $error("ready low too long");
   a_we_unlock: assert property (setup_we_o |-> setup_unlocked_o)
      else $error("write while locked");
   a_we_area: assert property (setup_we_o |-> setup_addr_o inside {[8'h8d:8'hfa]})
      else $error("write outside setup area");
   a_we_frame: assert property (setup_we_o |-> !ss_n_i)
      else $error("write outside a frame");
   a_addr_next: assert property (setup_we_o && seen_q |-> setup_addr_o == last_q + 8'h01)
      else $error("write location not consecutive");
   a_fall_frame: assert property ($fell(byte_ready_handshake_o) |-> !ss_n_i)
      else $error("ready fell with no byte");
   a_reset_out: assert property ($fell(rst_i) |-> byte_ready_handshake_o && !setup_we_o && !setup_unlocked_o)
      else $error("bad state after reset");
endmodule

bind tks_spi_access tks_chk i_tks_chk
(
   .ref_clk_i(ref_clk_i),
   .rst_i(rst_i),
   .ss_n_i(ss_n_i),
   .byte_ready_handshake_o(byte_ready_handshake_o),
   .setup_we_o(setup_we_o),
   .setup_addr_o(setup_addr_o),
   .setup_unlocked_o(setup_unlocked_o)
);

// ===== test/tks_spi_access_tb_top.sv
// Bench: write rows through the host model, then read and lock cases.
// Assumes tks_host as master and tks_chk bound to the design.
`timescale 1ns/1ps
`include "tks_map.vh"
module tks_spi_access_tb_top;
   localparam TICK = 100;
   // en: setup writes expected; the unlock byte is not a setup write
   typedef struct { logic [7:0] loc, cnt, d0, d1, ea, ed, en; } tks_row_t;
   tks_row_t   rows [2] = '{
      '{8'h8c, 8'h02, 8'hfe, 8'h5a, 8'h8d, 8'h5a, 8'h01},
      '{8'hf9, 8'h02, 8'h11, 8'h22, 8'hfa, 8'h22, 8'h02}};
   logic       ref_clk_i = 1'b0;
   logic       rst_i     = 1'b1;
   logic       fail      = 1'b0;
   logic       scan      = 1'b0;
   logic       sclk, ss_n, mosi, miso, rdy, we, unl;
   logic [7:0] wa, wd, last_a, last_d, rx, dt;
   logic [7:0] rb [5];
   logic [15:0] c;
   integer     errors = 0, n_checks = 0, cyc = 0, n_we = 0, n0, c0, k;
   wire [7:0]  rdat = ~wa;

   always #5 ref_clk_i = ~ref_clk_i;

   tks_spi_access #(.TICK_CYC(TICK)) i_tks_spi_access
   (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso),
      .byte_ready_handshake_o(rdy), .capture_fail_i(fail),
      .scan_start_i(scan), .setup_we_o(we), .setup_addr_o(wa),
      .setup_wdata_o(wd), .setup_rdata_i(rdat), .setup_unlocked_o(unl)
   );

   tks_host i_tks_host
   (
      .ready_i(rdy), .miso_i(miso), .sclk_o(sclk), .ss_n_o(ss_n),
      .mosi_o(mosi)
   );

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, s);
      n_checks++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask

   // Reference checksum, one byte MSB first
   function automatic logic [15:0] crc(input logic [15:0] v, logic [7:0] b);
      integer i;
      v = v ^ {b, 8'h00};
      for (i = 0; i < 8; i++)
         v = v[15] ? (v << 1) ^ `TKS_CRC_POLY : v << 1;
      return v;
   endfunction

   // Cycle count, hang guard and write strobe capture
   always @(posedge ref_clk_i)
   begin
      cyc = cyc + 1;
      if (we === 1'b1)
      begin
         n_we++;
         last_a = wa;
         last_d = wd;
      end
      if (cyc > 96000)
      begin
         errors++;
         complete_run();
      end
   end

   initial
   begin
      repeat (2) @(negedge ref_clk_i);
      chk("rst_ready", 16'h1, {15'h0, rdy});
      chk("rst_unlock", 16'h0, {15'h0, unl});
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      // Five capture failures and three scan starts
      for (k = 0; k < 5; k++)
      begin
         @(negedge ref_clk_i);
         fail = 1'b1;
         scan = (k < 3);
         @(negedge ref_clk_i);
         fail = 1'b0;
         scan = 1'b0;
      end
      for (k = 0; k < 2; k++)
      begin
         n0 = n_we;
         i_tks_host.xfer(rows[k].loc, rx);
         i_tks_host.xfer(rows[k].cnt, rx);
         i_tks_host.xfer(rows[k].d0, rx);
         i_tks_host.xfer(rows[k].d1, rx);
         i_tks_host.done_frame();
         chk("we_count", 16'(n0 + rows[k].en), 16'(n_we));
         chk("we_addr", {8'h0, rows[k].ea}, {8'h0, last_a});
         chk("we_data", {8'h0, rows[k].ed}, {8'h0, last_d});
         chk("unlocked", 16'h1, {15'h0, unl});
         $display("row %0d done", k);
      end
      // Read the three counters and the checksum
      c0 = cyc;
      i_tks_host.xfer(8'h02, rx);
      i_tks_host.xfer(8'h83, rx);
      for (k = 0; k < 5; k++)
         i_tks_host.xfer(8'h00, rb[k]);
      i_tks_host.done_frame();
      // Tick advance against the bench's own cycle count
      dt = rb[0] - 8'(c0 / TICK);
      chk("tick", 16'h1, {15'h0, dt >= 8'd40 && dt <= 8'd45});
      chk("fails", 16'h5, {8'h0, rb[1]});
      chk("scans", 16'h3, {8'h0, rb[2]});
      c = crc(crc(crc(`TKS_CRC_INIT, 8'h02), 8'h83), rb[0]);
      c = crc(crc(c, 8'h05), 8'h03);
      chk("crc", c, {rb[4], rb[3]});
      chk("relock", 16'h0, {15'h0, unl});
      $display("read done");
      // A write while locked is dropped
      n0 = n_we;
      i_tks_host.xfer(8'h8d, rx);
      i_tks_host.xfer(8'h01, rx);
      i_tks_host.xfer(8'h77, rx);
      i_tks_host.done_frame();
      chk("locked_we", 16'(n0), 16'(n_we));
      $display("locked write done");
      complete_run();
   end
endmodule
